// ---- bjn_regs.svh ----
/*
  constants for the branch/jump next-pc unit: opcode and function codes,
  link register index, reset pc.
  assumes a 32-bit instruction word in the classic three-format layout.
*/
`ifndef BJN_REGS_SVH
`define BJN_REGS_SVH
`define BJN_OP_SPECIAL   6'h00
`define BJN_OP_REGIMM    6'h01
`define BJN_OP_GOTO      6'h02
`define BJN_OP_CALL      6'h03
`define BJN_OP_EQ        6'h04
`define BJN_OP_NE        6'h05
`define BJN_OP_NONPOS    6'h06
`define BJN_OP_POS       6'h07
`define BJN_FN_RGOTO     6'h08
`define BJN_FN_RCALL     6'h09
`define BJN_FN_SYSSVC    6'h0C
`define BJN_FN_DEBUG     6'h0D
`define BJN_RI_NEG       5'h00
`define BJN_RI_NONNEG    5'h01
`define BJN_RI_CALLNEG   5'h10
`define BJN_RI_CALLNN    5'h11
`define BJN_LINK_GPR     5'h1F
`define BJN_RESET_PC     32'hBFC00000
`define BJN_INSN_BYTES   32'h00000004
`endif

// ---- bjn_pkg.sv ----
/*
  types for the branch/jump next-pc unit.
  assumes bjn_regs.svh is on the include path.
*/
package bjn_pkg;
  typedef struct packed {
    logic        valid;
    logic [31:0] insn;
    logic [31:0] source_reg_a;
    logic [31:0] source_reg_b;
  } bjn_issue_s;
  typedef struct packed {
    logic        valid;
    logic [4:0]  gpr;
    logic [31:0] value;
  } bjn_link_s;
  typedef enum logic [1:0] {
    BJN_SEQ,
    BJN_SLOT,
    BJN_TRAP
  } bjn_state_e;
endpackage

// ---- bjn_next_pc.sv ----
/*
  branch/jump next-pc unit: decodes control transfers, forms next pc,
  link writes and trap requests.
  assumes fetch gives one instruction per issue_i.valid with its operands,
  and the exception unit redirects fetch after a trap request.
*/
`timescale 1ns/1ps
`include "bjn_regs.svh"
module bjn_next_pc
  import bjn_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire bjn_issue_s  issue_i,
  output logic [31:0]      pc_o,
  output bjn_link_s        link_o,
  output logic             system_service_trap_trap_o,
  output logic             break_trap_o,
  output logic             taken_o
);

  function automatic logic is_neg(input logic [31:0] v);
    return v[31];
  endfunction

  function automatic logic is_zero(input logic [31:0] v);
    return v == 32'h00000000;
  endfunction

  bjn_state_e  state_reg, state_next;
  logic [31:0] pc_reg, pc_next;
  logic [31:0] target_reg, target_next;
  logic        pend_reg, pend_next;
  bjn_link_s   link_reg, link_next;
  logic        sys_reg, sys_next;
  logic        brk_reg, brk_next;
  logic        taken_reg, taken_next;

  logic [5:0]  opc;
  logic [5:0]  fn;
  logic [4:0]  ra_idx;
  logic [4:0]  rb_idx;
  logic [4:0]  rd_idx;
  logic [31:0] seq_pc;
  logic [31:0] link_pc;
  logic [31:0] br_tgt;
  logic [31:0] abs_tgt;
  logic [31:0] a;
  logic [31:0] b;

  assign opc    = issue_i.insn[31:26];
  assign fn     = issue_i.insn[5:0];
  assign ra_idx = issue_i.insn[25:21];
  assign rb_idx = issue_i.insn[20:16];
  assign rd_idx = issue_i.insn[15:11];
  assign a      = issue_i.source_reg_a;
  assign b      = issue_i.source_reg_b;
  assign seq_pc  = pc_reg + `BJN_INSN_BYTES;
  assign link_pc = pc_reg + `BJN_INSN_BYTES + `BJN_INSN_BYTES;
  assign abs_tgt = {pc_reg[31:28], issue_i.insn[25:0], 2'b00};
  assign br_tgt  = seq_pc
                 + {{14{issue_i.insn[15]}}, issue_i.insn[15:0], 2'b00};

  always_comb begin
    logic xfer;
    logic take;
    logic [31:0] tgt;
    xfer        = 1'b0;
    take        = 1'b0;
    tgt         = br_tgt;
    state_next  = state_reg;
    pc_next     = pc_reg;
    target_next = target_reg;
    pend_next   = pend_reg;
    link_next   = '0;
    sys_next    = 1'b0;
    brk_next    = 1'b0;
    taken_next  = 1'b0;
    if (issue_i.valid) begin
      unique case (opc)
        `BJN_OP_GOTO: begin
          xfer = 1'b1;
          take = 1'b1;
          tgt  = abs_tgt;
        end
        `BJN_OP_CALL: begin
          xfer = 1'b1;
          take = 1'b1;
          tgt  = abs_tgt;
          link_next = '{1'b1, `BJN_LINK_GPR, link_pc};
        end
        `BJN_OP_EQ: begin
          xfer = 1'b1;
          take = (a == b);
        end
        `BJN_OP_NE: begin
          xfer = 1'b1;
          take = (a != b);
        end
        `BJN_OP_NONPOS: begin
          xfer = 1'b1;
          take = is_neg(a) | is_zero(a);
        end
        `BJN_OP_POS: begin
          xfer = 1'b1;
          take = ~is_neg(a) & ~is_zero(a);
        end
        `BJN_OP_REGIMM: begin
          unique case (rb_idx)
            `BJN_RI_NEG: begin
              xfer = 1'b1;
              take = is_neg(a);
            end
            `BJN_RI_NONNEG: begin
              xfer = 1'b1;
              take = ~is_neg(a);
            end
            `BJN_RI_CALLNEG: begin
              xfer = 1'b1;
              take = is_neg(a);
              link_next = '{1'b1, `BJN_LINK_GPR, link_pc};
            end
            `BJN_RI_CALLNN: begin
              xfer = 1'b1;
              take = ~is_neg(a);
              link_next = '{1'b1, `BJN_LINK_GPR, link_pc};
            end
            default: ;
          endcase
        end
        `BJN_OP_SPECIAL: begin
          unique case (fn)
            `BJN_FN_RGOTO: begin
              xfer = 1'b1;
              take = 1'b1;
              tgt  = a;
            end
            `BJN_FN_RCALL: begin
              xfer = 1'b1;
              take = 1'b1;
              tgt  = a;
              link_next = '{1'b1, rd_idx, link_pc};
            end
            `BJN_FN_SYSSVC: sys_next = 1'b1;
            `BJN_FN_DEBUG:  brk_next = 1'b1;
            default: ;
          endcase
        end
        default: ;
      endcase
      if (sys_next | brk_next) begin
        state_next = BJN_TRAP;
        pend_next  = 1'b0;
      end else if (state_reg == BJN_SLOT) begin
        // the slot executes, then the pending target is taken
        pc_next    = pend_reg ? target_reg : seq_pc;
        pend_next  = 1'b0;
        state_next = BJN_SEQ;
      end else begin
        pc_next = seq_pc;
        if (xfer) begin
          state_next  = BJN_SLOT;
          pend_next   = take;
          target_next = tgt;
          taken_next  = take;
        end else begin
          state_next = BJN_SEQ;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= BJN_SEQ;
      pc_reg     <= `BJN_RESET_PC;
      target_reg <= 32'h00000000;
      pend_reg   <= 1'b0;
      link_reg   <= '0;
      sys_reg    <= 1'b0;
      brk_reg    <= 1'b0;
      taken_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      pc_reg     <= pc_next;
      target_reg <= target_next;
      pend_reg   <= pend_next;
      link_reg   <= link_next;
      sys_reg    <= sys_next;
      brk_reg    <= brk_next;
      taken_reg  <= taken_next;
    end
  end

  assign pc_o           = pc_reg;
  assign link_o         = link_reg;
  assign system_service_trap_trap_o = sys_reg;
  assign break_trap_o   = brk_reg;
  assign taken_o        = taken_reg;

  slot_then_target_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && state_reg == BJN_SLOT && pend_reg && !sys_next
     && !brk_next) |=> pc_reg == $past(target_reg))
    else $error("delay slot not followed by target");
  abs_target_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (taken_reg && state_reg == BJN_SLOT
     && ($past(opc) == `BJN_OP_GOTO || $past(opc) == `BJN_OP_CALL))
    |-> target_reg[31:28] == $past(pc_reg[31:28]))
    else $error("absolute target top bits wrong");
  call_link_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && state_reg == BJN_SEQ && opc == `BJN_OP_CALL)
    |=> link_reg.valid && link_reg.gpr == `BJN_LINK_GPR
        && link_reg.value == $past(pc_reg) + 32'h00000008)
    else $error("absolute call link wrong");
  rcall_link_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && opc == `BJN_OP_SPECIAL && fn == `BJN_FN_RCALL)
    |=> link_reg.valid && link_reg.gpr == $past(rd_idx))
    else $error("register call link target wrong");
  eq_branch_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && state_reg == BJN_SEQ && opc == `BJN_OP_EQ)
    |=> taken_reg == ($past(a) == $past(b)))
    else $error("equal branch decision wrong");
  ne_branch_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && state_reg == BJN_SEQ && opc == `BJN_OP_NE)
    |=> taken_reg == ($past(a) != $past(b)))
    else $error("unequal branch decision wrong");
  pos_branch_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && state_reg == BJN_SEQ && opc == `BJN_OP_POS)
    |=> taken_reg == ($signed($past(a)) > 0))
    else $error("positive branch decision wrong");
  neg_branch_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && state_reg == BJN_SEQ && opc == `BJN_OP_REGIMM
     && rb_idx == `BJN_RI_NEG) |=> taken_reg == ($signed($past(a)) < 0))
    else $error("negative branch decision wrong");
  sign_call_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && opc == `BJN_OP_REGIMM && rb_idx[4]
     && rb_idx[3:1] == 3'h0) |=> link_reg.valid)
    else $error("sign call did not link");
  trap_format_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (sys_reg || brk_reg) |-> $past(opc) == `BJN_OP_SPECIAL)
    else $error("trap from wrong format");
  system_service_trap_now_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && opc == `BJN_OP_SPECIAL && fn == `BJN_FN_SYSSVC)
    |=> system_service_trap_trap_o && state_reg == BJN_TRAP)
    else $error("system service trap missing");
  break_now_a: assert property (@(posedge clk)
    disable iff (!nrst)
    (issue_i.valid && opc == `BJN_OP_SPECIAL && fn == `BJN_FN_DEBUG)
    |=> break_trap_o)
    else $error("breakpoint trap missing");

endmodule // bjn_next_pc

// ---- bjn_gpr_model.sv ----
/*
  register file model feeding operands to the next-pc unit.
  assumes link writes arrive as one-cycle pulses on clk.
*/
`timescale 1ns/1ps
module bjn_gpr_model
  import bjn_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [31:0] insn,
  input  wire bjn_link_s   link,
  output logic [31:0]      val_a,
  output logic [31:0]      val_b
);
  logic [31:0] gpr [32];
  // register zero always reads zero
  assign val_a = (insn[25:21] == 5'h00) ? 32'h0 : gpr[insn[25:21]];
  assign val_b = (insn[20:16] == 5'h00) ? 32'h0 : gpr[insn[20:16]];
  always @(posedge clk) begin
    if (link.valid === 1'b1) begin
      gpr[link.gpr] <= link.value;
    end
  end
endmodule // bjn_gpr_model

// ---- tb.sv ----
/*
  testbench for the next-pc unit: branches, jumps, links and traps.
  assumes bjn_regs.svh on the include path; inputs change at negedge.
*/
`timescale 1ns/1ps
`include "bjn_regs.svh"
`define CHK(g, e) chk(g, e)
module tb
  import bjn_pkg::*;
;
  logic        clk, nrst, vld, taken_o, sys_o, brk_o;
  logic [31:0] insn, ra, rb, pc_o, p, q;
  bjn_issue_s  iss_s;
  bjn_link_s   link_o;
  int          n_fail, total_checks;
  assign iss_s = '{vld, insn, ra, rb};
  bjn_next_pc dut (.clk(clk), .nrst(nrst), .issue_i(iss_s), .pc_o(pc_o),
    .link_o(link_o), .system_service_trap_trap_o(sys_o), .break_trap_o(brk_o),
    .taken_o(taken_o));
  bjn_gpr_model g (.clk(clk), .insn(insn), .link(link_o), .val_a(ra),
    .val_b(rb));
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] gv, ev);
    total_checks++;
    if (gv !== ev) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask
  task automatic step(input logic [31:0] i);
    vld = 1'b1;
    insn = i;
    @(negedge clk);
  endtask
  task automatic sc_br(input logic [5:0] op, input logic [4:0] rt,
                       input logic [31:0] a, b, input logic t);
    g.gpr[1] = a;
    g.gpr[2] = b;
    q = p + 32'h4 + 32'hFFFFFFF8;
    step({op, 5'h01, rt, 16'hFFFE});
    `CHK(taken_o, t);
    `CHK(pc_o, p + 32'h4);
    `CHK(link_o.valid, rt[4]);
    if (rt[4]) `CHK({link_o.gpr, link_o.value}, {5'h1F, p + 32'h8});
    step(32'h0);
    `CHK(pc_o, t ? q : p + 32'h8);
    p = t ? q : p + 32'h8;
  endtask
  task automatic sc_jmp(input logic [5:0] op);
    step({op, 26'h2AAAAAA});
    `CHK(pc_o, p + 32'h4);
    `CHK(link_o.valid, op[0]);
    if (op[0]) `CHK({link_o.gpr, link_o.value}, {5'h1F, p + 32'h8});
    step(32'h0);
    `CHK(pc_o, {p[31:28], 26'h2AAAAAA, 2'b00});
    p = {p[31:28], 26'h2AAAAAA, 2'b00};
  endtask
  task automatic sc_rj(input logic [5:0] fn);
    g.gpr[3] = 32'h12345678;
    step({6'h00, 5'h03, 5'h00, 5'h05, 5'h00, fn});
    `CHK(link_o.valid, fn[0]);
    if (fn[0]) `CHK({link_o.gpr, link_o.value}, {5'h05, p + 32'h8});
    step(32'h0);
    `CHK(pc_o, 32'h12345678);
    p = 32'h12345678;
  endtask
  task automatic sc_trap(input logic [5:0] op, fn, input logic s, b);
    step({op, 20'h00000, fn});
    `CHK({sys_o, brk_o}, {s, b});
    `CHK(pc_o, (s | b) ? p : p + 32'h4);
    step(32'h0);
    `CHK({sys_o, brk_o}, 2'b00);
    `CHK(pc_o, p + ((s | b) ? 32'h4 : 32'h8));
    p = p + ((s | b) ? 32'h4 : 32'h8);
  endtask
  task automatic sc_rst();
    step({`BJN_OP_GOTO, 26'h0000010});
    `CHK(pc_o, p + 32'h4);
    nrst = 1'b0;
    vld = 1'b0;
    @(negedge clk);
    `CHK({pc_o, taken_o, link_o.valid}, {`BJN_RESET_PC, 2'b00});
    nrst = 1'b1;
    p = `BJN_RESET_PC;
    step(32'h0);
    `CHK(pc_o, p + 32'h4);
    p = p + 32'h4;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    vld = 1'b0;
    insn = 32'h0;
    n_fail = 0;
    total_checks = 0;
    p = `BJN_RESET_PC;
    for (int k = 0; k < 32; k++) g.gpr[k] = 32'(k);
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    sc_br(`BJN_OP_EQ, 5'h02, 32'h5, 32'h5, 1'b1);
    sc_br(`BJN_OP_EQ, 5'h02, 32'h5, 32'h6, 1'b0);
    sc_br(`BJN_OP_NE, 5'h02, 32'h5, 32'h6, 1'b1);
    sc_br(`BJN_OP_NE, 5'h02, 32'h7, 32'h7, 1'b0);
    sc_br(`BJN_OP_NONPOS, 5'h00, 32'h0, 32'h0, 1'b1);
    sc_br(`BJN_OP_NONPOS, 5'h00, 32'h1, 32'h0, 1'b0);
    sc_br(`BJN_OP_POS, 5'h00, 32'h1, 32'h0, 1'b1);
    sc_br(`BJN_OP_POS, 5'h00, 32'h80000000, 32'h0, 1'b0);
    sc_br(`BJN_OP_NONPOS, 5'h00, 32'hFFFFFFF0, 32'h0, 1'b1);
    sc_br(`BJN_OP_POS, 5'h00, 32'h0, 32'h0, 1'b0);
    sc_br(`BJN_OP_REGIMM, `BJN_RI_NEG, 32'hFFFFFFFF, 32'h0, 1'b1);
    sc_br(`BJN_OP_REGIMM, `BJN_RI_NEG, 32'h0, 32'h0, 1'b0);
    sc_br(`BJN_OP_REGIMM, `BJN_RI_NONNEG, 32'h0, 32'h0, 1'b1);
    sc_br(`BJN_OP_REGIMM, `BJN_RI_NONNEG, 32'h80000000, 32'h0, 1'b0);
    sc_br(`BJN_OP_REGIMM, `BJN_RI_CALLNEG, 32'h80000000, 32'h0,
          1'b1);
    sc_br(`BJN_OP_REGIMM, `BJN_RI_CALLNN, 32'h80000000, 32'h0, 1'b0);
    sc_br(`BJN_OP_REGIMM, `BJN_RI_CALLNN, 32'h7FFFFFFF, 32'h0, 1'b1);
    sc_jmp(`BJN_OP_GOTO);
    sc_jmp(`BJN_OP_CALL);
    sc_rj(`BJN_FN_RGOTO);
    sc_rj(`BJN_FN_RCALL);
    sc_trap(`BJN_OP_SPECIAL, `BJN_FN_SYSSVC, 1'b1, 1'b0);
    sc_trap(`BJN_OP_SPECIAL, `BJN_FN_DEBUG, 1'b0, 1'b1);
    sc_trap(`BJN_OP_REGIMM, `BJN_FN_SYSSVC, 1'b0, 1'b0);
    sc_rst();
    vld = 1'b0;
    finish_test();
  end
endmodule // tb
